// *** rtl/pict_timer.sv ***
// Pulse interval capture timer: counter, capture, spike filter, registers.
// Assumes pins synchronous to clk and an Avalon-MM master on the bus.
//
// Function
// - Clearing run halts counter until set
// - Run rising loads reload, clears wrap flag
// - Idle keeps running unless shutoff bit set
// - Power-down stops counting, capture, filter interrupts
// - Overflow sets wrap flag; software clears
// - Step A selects divide by 8 or 16 (64 or 128 with step B)
// - Live mode disables capture, reads count
// - Refresh bit reloads counter on capture
// - Rise and fall bits select capture edges
// - Select bit picks pin 3.3 or 3.2
// - Divisions 8, 16, 64, 128 of clock
// - First bit shows first spike-filter event
// - Start bit arms filter; second event interrupts
// - Route 0 picks pin 3.3 or filter
// - Route 1 picks pin 3.2 or filter
// - Control and route registers reset zero
// - Sixteen-bit up counter measures intervals
// - Run set also clears first bit
// - Start and live bits choose mode
// - Short or wrapped second event is suppressed
`timescale 1ns/1ps
`default_nettype none
module pict_timer
    import pict_pkg::*;
#(
    parameter int CNT_W = 16
)(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [PICT_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins
    input wire logic pin_p32,
    input wire logic pin_p33,
    // Interrupt lines to the controller
    output logic int_line_0,
    output logic int_line_1,
    // Filter interrupt pulse
    output logic filter_irq
);
    logic [7:0] ctl_a_q;
    logic [7:0] ctl_b_q;
    logic [7:0] route_q;
    logic [7:0] power_q;
    logic [CNT_W-1:0] reload_q;
    logic [CNT_W-1:0] thresh_q;
    logic [CNT_W-1:0] capt_q;
    logic [CNT_W-1:0] cnt_q;
    logic run_q;
    logic in_q;
    logic irq_q;
    logic ack_q;
    logic [31:0] rdata_q;
    pict_mode_t mode;

    // Bus decode; one wait state so every access completes on the second edge
    wire logic [7:0] idx_w;
    wire logic mapped_w;
    wire logic wr_w;
    wire logic lane0_w;
    assign idx_w = avs_address[PICT_ADDR_W-1:2];
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_w = avs_write && ack_q;
    assign lane0_w = avs_byteenable[0];
    assign mapped_w = (idx_w == PICT_IDX_RELOAD_LOW) ||
        (idx_w == PICT_IDX_RELOAD_HIGH) || (idx_w == PICT_IDX_CAPTURE_HIGH) ||
        (idx_w == PICT_IDX_CAPTURE_LOW) || (idx_w == PICT_IDX_THRESHOLD_LOW) ||
        (idx_w == PICT_IDX_THRESHOLD_HIGH) || (idx_w == PICT_IDX_CONTROL_A) ||
        (idx_w == PICT_IDX_CONTROL_B) || (idx_w == PICT_IDX_INT_ROUTE) ||
        (idx_w == PICT_IDX_POWER);
    // Registers are one byte wide, so the upper write lanes are ignored
    wire logic [7:0] wb_w;
    assign wb_w = avs_writedata[7:0];
    wire logic wr_ctl_a;
    wire logic wr_ctl_b;
    wire logic wr_route;
    wire logic wr_power;
    wire logic wr_rel_l;
    wire logic wr_rel_h;
    wire logic wr_thr_l;
    wire logic wr_thr_h;
    assign wr_ctl_a = wr_w && lane0_w && (idx_w == PICT_IDX_CONTROL_A);
    assign wr_ctl_b = wr_w && lane0_w && (idx_w == PICT_IDX_CONTROL_B);
    assign wr_route = wr_w && lane0_w && (idx_w == PICT_IDX_INT_ROUTE);
    assign wr_power = wr_w && lane0_w && (idx_w == PICT_IDX_POWER);
    assign wr_rel_l = wr_w && lane0_w && (idx_w == PICT_IDX_RELOAD_LOW);
    assign wr_rel_h = wr_w && lane0_w && (idx_w == PICT_IDX_RELOAD_HIGH);
    assign wr_thr_l = wr_w && lane0_w && (idx_w == PICT_IDX_THRESHOLD_LOW);
    assign wr_thr_h = wr_w && lane0_w && (idx_w == PICT_IDX_THRESHOLD_HIGH);

    // Power gating
    wire logic active_w;
    assign active_w = !power_q[PICT_P_DOWN] &&
        !(power_q[PICT_P_IDLE] && power_q[PICT_P_SHUTOFF]);

    // Mode decode
    assign mode = ctl_a_q[PICT_A_LIVE] ? PICT_MODE_LIVE :
        (ctl_b_q[PICT_B_START] ? PICT_MODE_SPIKE : PICT_MODE_NORMAL);

    // Run edge and counting
    wire logic run_bit_w;
    wire logic run_rise_w;
    wire logic counting_w;
    wire logic tick_w;
    wire logic wrap_w;
    assign run_bit_w = ctl_a_q[PICT_A_RUN];
    assign run_rise_w = run_bit_w && !run_q;
    assign counting_w = run_bit_w && !run_rise_w && active_w;

    pict_divider #(
        .DIV_W(PICT_DIV_W)
    ) u_div (
        .clk(clk),
        .reset_n(reset_n),
        .enable(counting_w),
        .step_sel({ctl_b_q[PICT_B_STEP_B], ctl_a_q[PICT_A_STEP_A]}),
        .tick(tick_w)
    );
    assign wrap_w = tick_w && (cnt_q == {CNT_W{1'b1}});

    // Edge detection on the selected pin
    wire logic in_w;
    wire logic rise_w;
    wire logic fall_w;
    wire logic event_w;
    assign in_w = ctl_a_q[PICT_A_SEL] ? pin_p33 : pin_p32;
    assign rise_w = in_w && !in_q;
    assign fall_w = !in_w && in_q;
    assign event_w = counting_w && (mode != PICT_MODE_LIVE) &&
        ((rise_w && ctl_a_q[PICT_A_RISE]) ||
         (fall_w && ctl_a_q[PICT_A_FALL]));

    // Spike filter decisions
    wire logic spike_w;
    wire logic first_ev_w;
    wire logic second_ev_w;
    wire logic bad_w;
    wire logic rearm_w;
    wire logic pass_w;
    wire logic reload_ev_w;
    wire logic clr_wrap_w;
    wire logic [CNT_W-1:0] cnt_next_w;
    assign spike_w = (mode == PICT_MODE_SPIKE);
    assign first_ev_w = event_w && spike_w && !ctl_b_q[PICT_B_FIRST];
    assign second_ev_w = event_w && spike_w && ctl_b_q[PICT_B_FIRST];
    assign bad_w = (cnt_q <= thresh_q) || ctl_a_q[PICT_A_WRAP];
    assign pass_w = second_ev_w && !bad_w;
    // A rejected pulse waits for the matching edge unless both edges count
    assign rearm_w = second_ev_w && bad_w &&
        !(ctl_a_q[PICT_A_RISE] && ctl_a_q[PICT_A_FALL]);
    assign reload_ev_w = first_ev_w || (second_ev_w && bad_w) ||
        (event_w && !spike_w && ctl_a_q[PICT_A_REFRESH]) ||
        (pass_w && ctl_a_q[PICT_A_REFRESH]);
    assign clr_wrap_w = run_rise_w || first_ev_w || (second_ev_w && bad_w);
    assign cnt_next_w = cnt_q + 1'b1;

    // Control A with hardware-set, software-writable wrap flag; overflow wins over clear
    logic [7:0] ctl_a_d;
    always_comb
    begin
        ctl_a_d = ctl_a_q;
        if (wr_ctl_a)
            ctl_a_d = wb_w;
        if (clr_wrap_w)
            ctl_a_d[PICT_A_WRAP] = 1'b0;
        if (wrap_w && !run_rise_w)
            ctl_a_d[PICT_A_WRAP] = 1'b1;
    end

    // Control B: first bit is hardware-owned
    logic [7:0] ctl_b_d;
    always_comb
    begin
        ctl_b_d = ctl_b_q;
        if (wr_ctl_b)
        begin
            ctl_b_d = wb_w;
            ctl_b_d[PICT_B_FIRST] = ctl_b_q[PICT_B_FIRST];
        end
        ctl_b_d[7:3] = 5'h00;
        if (!spike_w || run_rise_w)
            ctl_b_d[PICT_B_FIRST] = 1'b0;
        else if (first_ev_w || rearm_w)
            ctl_b_d[PICT_B_FIRST] = 1'b1;
        else if (second_ev_w)
            ctl_b_d[PICT_B_FIRST] = 1'b0;
    end

    // Counter next value
    logic [CNT_W-1:0] cnt_d;
    always_comb
    begin
        cnt_d = cnt_q;
        if (run_rise_w || (reload_ev_w && active_w))
            cnt_d = reload_q;
        else if (tick_w)
            cnt_d = cnt_next_w;
    end

    // Read mux; capture reads live count in live mode
    wire logic [CNT_W-1:0] capt_view_w;
    logic [7:0] rd_byte;
    assign capt_view_w = (mode == PICT_MODE_LIVE) ? cnt_q : capt_q;
    always_comb
    begin
        case (idx_w)
            PICT_IDX_RELOAD_LOW: rd_byte = reload_q[7:0];
            PICT_IDX_RELOAD_HIGH: rd_byte = reload_q[15:8];
            PICT_IDX_CAPTURE_HIGH: rd_byte = capt_view_w[15:8];
            PICT_IDX_CAPTURE_LOW: rd_byte = capt_view_w[7:0];
            PICT_IDX_THRESHOLD_LOW: rd_byte = thresh_q[7:0];
            PICT_IDX_THRESHOLD_HIGH: rd_byte = thresh_q[15:8];
            PICT_IDX_CONTROL_A: rd_byte = ctl_a_q;
            PICT_IDX_CONTROL_B: rd_byte = ctl_b_q;
            PICT_IDX_INT_ROUTE: rd_byte = route_q;
            PICT_IDX_POWER: rd_byte = power_q;
            default: rd_byte = PICT_RESET_BYTE;
        endcase
    end

    // Control registers; hardware-owned bits live in the next values
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctl_a_q <= PICT_RESET_BYTE;
            ctl_b_q <= PICT_RESET_BYTE;
        end
        else
        begin
            ctl_a_q <= ctl_a_d;
            ctl_b_q <= ctl_b_d;
        end
    end

    // Route keeps only its two source bits; the rest read as zero
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            route_q <= PICT_RESET_BYTE;
        else if (wr_route)
            route_q <= {wb_w[7:6], 6'h00};
    end

    // Power request bits: shutoff, idle and power-down
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            power_q <= PICT_RESET_BYTE;
        else if (wr_power)
            power_q <= {5'h00, wb_w[2:0]};
    end

    // Halves are written one at a time with no shadow latch
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            reload_q <= '0;
        else if (wr_rel_l)
            reload_q[7:0] <= wb_w;
        else if (wr_rel_h)
            reload_q[15:8] <= wb_w;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            thresh_q <= '0;
        else if (wr_thr_l)
            thresh_q[7:0] <= wb_w;
        else if (wr_thr_h)
            thresh_q[15:8] <= wb_w;
    end

    // Counter and capture
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cnt_q <= '0;
            capt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            if (event_w)
                capt_q <= cnt_q;
        end
    end

    // Previous samples for edge detection and the filter pulse
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            run_q <= 1'b0;
            in_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            run_q <= run_bit_w;
            in_q <= in_w;
            irq_q <= pass_w;
        end
    end

    // Bus answer
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            if (avs_read && !ack_q)
                rdata_q <= mapped_w ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end
    assign avs_readdata = rdata_q;

    // Interrupt routing; filter pulse only while the block is powered
    assign filter_irq = irq_q && active_w;
    assign int_line_0 = route_q[PICT_R_ROUTE_0] ? filter_irq : pin_p33;
    assign int_line_1 = route_q[PICT_R_ROUTE_1] ? filter_irq : pin_p32;
endmodule : pict_timer
`default_nettype wire

// *** common/pict_pkg.sv ***
// Package for the pulse interval capture timer: offsets, fields, divisors.
// Assumes a 40 MHz system clock and an Avalon-MM byte-addressed bus.
package pict_pkg;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] PICT_IDX_RELOAD_LOW = 8'hB7;
    localparam logic [7:0] PICT_IDX_RELOAD_HIGH = 8'hB9;
    localparam logic [7:0] PICT_IDX_CAPTURE_HIGH = 8'hBA;
    localparam logic [7:0] PICT_IDX_CAPTURE_LOW = 8'hBB;
    localparam logic [7:0] PICT_IDX_THRESHOLD_LOW = 8'hBC;
    localparam logic [7:0] PICT_IDX_THRESHOLD_HIGH = 8'hBD;
    localparam logic [7:0] PICT_IDX_CONTROL_A = 8'hBE;
    localparam logic [7:0] PICT_IDX_CONTROL_B = 8'hBF;
    localparam logic [7:0] PICT_IDX_INT_ROUTE = 8'hDE;
    localparam logic [7:0] PICT_IDX_POWER = 8'hC0;
    localparam int PICT_ADDR_W = 10;
    // Control A fields
    localparam int PICT_A_WRAP = 7;
    localparam int PICT_A_STEP_A = 6;
    localparam int PICT_A_LIVE = 5;
    localparam int PICT_A_REFRESH = 4;
    localparam int PICT_A_RUN = 3;
    localparam int PICT_A_RISE = 2;
    localparam int PICT_A_FALL = 1;
    localparam int PICT_A_SEL = 0;
    // Control B fields
    localparam int PICT_B_STEP_B = 2;
    localparam int PICT_B_FIRST = 1;
    localparam int PICT_B_START = 0;
    // Interrupt route fields
    localparam int PICT_R_ROUTE_1 = 7;
    localparam int PICT_R_ROUTE_0 = 6;
    // Power control fields
    localparam int PICT_P_SHUTOFF = 0;
    localparam int PICT_P_IDLE = 1;
    localparam int PICT_P_DOWN = 2;
    localparam logic [7:0] PICT_RESET_BYTE = 8'h00;
    // Counter clock divisors of the system clock
    localparam int PICT_DIV_00 = 8;
    localparam int PICT_DIV_01 = 16;
    localparam int PICT_DIV_10 = 64;
    localparam int PICT_DIV_11 = 128;
    localparam int PICT_DIV_W = 7;
    typedef enum logic [1:0] {PICT_MODE_NORMAL, PICT_MODE_SPIKE,
                              PICT_MODE_LIVE} pict_mode_t;
endpackage : pict_pkg

// *** rtl/pict_divider.sv ***
// Counter tick generator: a pulse every divisor system clocks.
// Assumes clk and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pict_divider
    import pict_pkg::*;
#(
    parameter int DIV_W = PICT_DIV_W
)(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic enable,
    input wire logic [1:0] step_sel,
    // Tick out
    output logic tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    wire logic [DIV_W-1:0] last_w;
    assign last_w = (step_sel == 2'h0) ? DIV_W'(PICT_DIV_00 - 1) :
                    (step_sel == 2'h1) ? DIV_W'(PICT_DIV_01 - 1) :
                    (step_sel == 2'h2) ? DIV_W'(PICT_DIV_10 - 1) :
                    DIV_W'(PICT_DIV_11 - 1);
    assign tick = enable && (cnt_q >= last_w);
    assign cnt_d = !enable ? '0 : (tick ? '0 : cnt_q + 1'b1);
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule : pict_divider
`default_nettype wire

// *** test/pict_timer_monitor.sv ***
// Port checker for the pulse interval capture timer.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pict_timer_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins and interrupts
    input wire logic pin_p32,
    input wire logic pin_p33,
    input wire logic int_line_0,
    input wire logic int_line_1,
    input wire logic filter_irq
);
    logic [3:0] since_q;
    logic [1:0] pins_q;
    // Cycles since the last pin change, saturating
    always_ff @(posedge clk)
    begin
        pins_q <= {pin_p33, pin_p32};
        if (!reset_n)
            since_q <= 4'hF;
        else if ({pin_p33, pin_p32} != pins_q)
            since_q <= 4'h0;
        else if (since_q != 4'hF)
            since_q <= since_q + 4'h1;
    end
    sequence req_rise;
        $rose(avs_read || avs_write);
    endsequence
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_bus_wait: assert property (req_rise |-> one_wait)
        else $error("wait state count wrong");
    chk_reset_zero: assert property ($rose(reset_n) |->
        avs_readdata == 32'h0 && !filter_irq)
        else $error("outputs not clear after reset");
    chk_read_upper: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    chk_line_zero: assert property (int_line_0 == pin_p33 ||
        int_line_0 == filter_irq)
        else $error("line 0 source wrong");
    chk_line_one: assert property (int_line_1 == pin_p32 ||
        int_line_1 == filter_irq)
        else $error("line 1 source wrong");
    chk_irq_pulse: assert property (filter_irq |=> !filter_irq)
        else $error("filter pulse too long");
    chk_irq_cause: assert property (filter_irq |-> since_q <= 4'h6)
        else $error("filter pulse without pin edge");
endmodule : pict_timer_monitor
bind pict_timer pict_timer_monitor u_pict_timer_monitor (.clk(clk),
    .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_p32(pin_p32), .pin_p33(pin_p33), .int_line_0(int_line_0),
    .int_line_1(int_line_1), .filter_irq(filter_irq));
`default_nettype wire

// *** test/pict_pin_source.sv ***
// Model of the external pulse source on the two capture pins.
// Assumes the bench calls pulse from its own thread.
`timescale 1ns/1ps
`default_nettype none
module pict_pin_source (
    // Clock
    input wire logic clk,
    // Pins
    output logic pin_p32,
    output logic pin_p33
);
    initial
    begin
        pin_p32 = 1'b0;
        pin_p33 = 1'b0;
    end
    // Idle low; a pulse is a high level held for whole clocks
    task automatic pulse(input logic pin, input int high);
        @(posedge clk);
        pin_p33 <= pin;
        pin_p32 <= !pin;
        repeat (high) @(posedge clk);
        pin_p32 <= 1'b0;
        pin_p33 <= 1'b0;
    endtask : pulse
endmodule : pict_pin_source
`default_nettype wire

// *** test/pict_timer_bench.sv ***
// Self-checking bench for the pulse interval capture timer.
// Assumes the 40 MHz clock; a bus wait ends only when waitrequest drops.
`timescale 1ns/1ps
`default_nettype none
module pict_timer_bench
    import pict_pkg::*;
;
    logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic pin_p32, pin_p33, int_line_0, int_line_1, filter_irq;
    logic [7:0] rv, v;
    int fails = 0, check_count = 0, cyc = 0, irqs = 0, n0;
    int hits0 = 0, hits1 = 0, h0, h1;
    pict_timer u_pict_timer (.clk(clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_p32(pin_p32),
        .pin_p33(pin_p33), .int_line_0(int_line_0),
        .int_line_1(int_line_1), .filter_irq(filter_irq));
    pict_pin_source u_pict_pin_source (.clk(clk), .pin_p32(pin_p32),
        .pin_p33(pin_p33));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Ceiling well above the roughly 7000 cycles the scenarios need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (filter_irq === 1'b1)
            irqs <= irqs + 1;
        if (int_line_0 === 1'b1)
            hits0 <= hits0 + 1;
        if (int_line_1 === 1'b1)
            hits1 <= hits1 + 1;
        if (cyc == 30000)
        begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [7:0] got, lo, hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            fails++;
            $display("unexpected at %0t: got %h", $time, got);
        end
    endtask : cmp
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] i, d);
        @(posedge clk);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rv = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [7:0] i, lo, hi);
        bus(1'b0, i, 8'h00);
        cmp(rv, lo, hi);
    endtask : rdc
    task automatic t_reset();
        rdc(PICT_IDX_CONTROL_A, 8'h00, 8'h00);
        rdc(PICT_IDX_CONTROL_B, 8'h00, 8'h00);
        rdc(PICT_IDX_INT_ROUTE, 8'h00, 8'h00);
        bus(1'b1, 8'h10, 8'h5A);
        rdc(8'h10, 8'h00, 8'h00);
        bus(1'b1, PICT_IDX_CAPTURE_LOW, 8'h77);
        rdc(PICT_IDX_CAPTURE_LOW, 8'h00, 8'h00);
    endtask : t_reset
    task automatic t_live();
        bus(1'b1, PICT_IDX_RELOAD_HIGH, 8'h12);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h28);
        rdc(PICT_IDX_CAPTURE_HIGH, 8'h12, 8'h12);
        repeat (80) @(posedge clk);
        rdc(PICT_IDX_CAPTURE_LOW, 8'h09, 8'h0E);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h20);
        bus(1'b0, PICT_IDX_CAPTURE_LOW, 8'h00);
        v = rv;
        repeat (80) @(posedge clk);
        rdc(PICT_IDX_CAPTURE_LOW, v, v);
    endtask : t_live
    task automatic t_wrap();
        bus(1'b1, PICT_IDX_RELOAD_HIGH, 8'hFF);
        bus(1'b1, PICT_IDX_RELOAD_LOW, 8'hFF);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h28);
        repeat (300) @(posedge clk);
        rdc(PICT_IDX_CONTROL_A, 8'hA8, 8'hA8);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h28);
        rdc(PICT_IDX_CONTROL_A, 8'h28, 8'h28);
        bus(1'b1, PICT_IDX_RELOAD_HIGH, 8'h00);
        bus(1'b1, PICT_IDX_RELOAD_LOW, 8'h00);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'hA0);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'hA8);
        rdc(PICT_IDX_CONTROL_A, 8'h28, 8'h28);
    endtask : t_wrap
    task automatic t_power();
        logic [7:0] pw [3] = '{8'h03, 8'h04, 8'h02};
        foreach (pw[k])
        begin
            bus(1'b1, PICT_IDX_POWER, 8'h00);
            bus(1'b1, PICT_IDX_CONTROL_A, 8'h20);
            bus(1'b1, PICT_IDX_CONTROL_A, 8'h28);
            bus(1'b1, PICT_IDX_POWER, pw[k]);
            bus(1'b0, PICT_IDX_CAPTURE_LOW, 8'h00);
            v = (k == 2) ? rv + 8'h09 : rv;
            repeat (80) @(posedge clk);
            rdc(PICT_IDX_CAPTURE_LOW, v, v + ((k == 2) ? 8'h03 : 8'h00));
        end
        bus(1'b1, PICT_IDX_POWER, 8'h00);
    endtask : t_power
    task automatic t_div();
        logic [7:0] e [4] = '{8'd160, 8'd80, 8'd20, 8'd10};
        foreach (e[k])
        begin
            bus(1'b1, PICT_IDX_CONTROL_B, {5'h0, k[1], 2'b00});
            bus(1'b1, PICT_IDX_CONTROL_A, {1'b0, k[0], 6'h20});
            bus(1'b1, PICT_IDX_CONTROL_A, {1'b0, k[0], 6'h28});
            repeat (1280) @(posedge clk);
            bus(1'b1, PICT_IDX_CONTROL_A, {1'b0, k[0], 6'h20});
            rdc(PICT_IDX_CAPTURE_LOW, e[k] - 8'h01, e[k] + 8'h02);
        end
        bus(1'b1, PICT_IDX_CONTROL_B, 8'h00);
    endtask : t_div
    task automatic t_cap();
        logic [7:0] c [4] = '{8'h1C, 8'h1A, 8'h1F, 8'h1D};
        logic [7:0] lo [4] = '{8'h09, 8'h0E, 8'h04, 8'h04};
        h0 = hits0;
        h1 = hits1;
        foreach (c[k])
        begin
            bus(1'b1, PICT_IDX_CONTROL_A, 8'h00);
            bus(1'b1, PICT_IDX_CONTROL_A, c[k]);
            repeat (80) @(posedge clk);
            u_pict_pin_source.pulse(k == 2, 40);
            repeat (8) @(posedge clk);
            rdc(PICT_IDX_CAPTURE_LOW, lo[k], lo[k] + 8'h03);
        end
        cmp(8'(hits0 - h0), 8'h28, 8'h28);
        cmp(8'(hits1 - h1), 8'h78, 8'h78);
    endtask : t_cap
    task automatic spike_round(input int gap);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h00);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h0D);
        repeat (80) @(posedge clk);
        u_pict_pin_source.pulse(1'b1, 4);
        repeat (gap) @(posedge clk);
    endtask : spike_round
    task automatic t_spike();
        bus(1'b1, PICT_IDX_INT_ROUTE, 8'hC0);
        h0 = hits0;
        h1 = hits1;
        bus(1'b1, PICT_IDX_THRESHOLD_LOW, 8'h03);
        bus(1'b1, PICT_IDX_THRESHOLD_HIGH, 8'h00);
        bus(1'b1, PICT_IDX_CONTROL_B, 8'h01);
        n0 = irqs;
        spike_round(80);
        rdc(PICT_IDX_CONTROL_B, 8'h03, 8'h03);
        u_pict_pin_source.pulse(1'b1, 4);
        repeat (8) @(posedge clk);
        rdc(PICT_IDX_CONTROL_B, 8'h01, 8'h01);
        cmp(8'(irqs - n0), 8'h01, 8'h01);
        spike_round(8);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h00);
        bus(1'b1, PICT_IDX_CONTROL_A, 8'h0D);
        rdc(PICT_IDX_CONTROL_B, 8'h01, 8'h01);
        spike_round(4);
        u_pict_pin_source.pulse(1'b1, 4);
        repeat (8) @(posedge clk);
        cmp(8'(irqs - n0), 8'h01, 8'h01);
        cmp(8'(hits0 - h0), 8'h01, 8'h01);
        cmp(8'(hits1 - h1), 8'h01, 8'h01);
    endtask : t_spike
    initial
    begin
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_live();
        t_wrap();
        t_power();
        t_div();
        t_cap();
        t_spike();
        stop_test();
    end
endmodule : pict_timer_bench
`default_nettype wire
